// ### core/ccr_pkg.sv
package ccr_pkg;

    // ==========================================
    // Command codes
    localparam logic [7:0] CCR_CMD_COMP = 8'hd0;
    localparam logic [7:0] CCR_CMD_VOUT = 8'hd1;
    localparam logic [7:0] CCR_CMD_OPS  = 8'hd2;

    // ==========================================
    // Reset values
    localparam logic [7:0] CCR_COMP_RST = 8'h09;
    localparam logic [7:0] CCR_VOUT_RST = 8'h40;
    localparam logic [7:0] CCR_OPS_RST  = 8'h05;

    // ==========================================
    // Writable bit masks
    localparam logic [7:0] CCR_COMP_MASK = 8'h1f;
    localparam logic [7:0] CCR_VOUT_MASK = 8'h7f;
    localparam logic [7:0] CCR_OPS_MASK  = 8'h07;

    // ==========================================
    // Field positions
    localparam int CCR_CFF_BIT     = 4;
    localparam int CCR_RAMP_LSB    = 1;
    localparam int CCR_SLAVE_BIT   = 0;
    localparam int CCR_DISCH_BIT   = 6;
    localparam int CCR_PGD_LSB     = 2;
    localparam int CCR_RANGE_LSB   = 0;
    localparam int CCR_FSW_LSB     = 1;
    localparam int CCR_LLM_BIT     = 0;

    // ==========================================
    // Power-good delay timing
    localparam int          CCR_CLK_MHZ     = 125;
    localparam int          CCR_MS_US       = 1000;
    localparam int          CCR_MS_CYCLES   = CCR_CLK_MHZ * CCR_MS_US;
    localparam logic [3:0]  CCR_PGD_ZERO    = 4'hf;

    // ==========================================
    // Frequency codes
    typedef enum logic [1:0] {
        CCR_FSW_400K  = 2'b00,
        CCR_FSW_600K  = 2'b01,
        CCR_FSW_800K  = 2'b10,
        CCR_FSW_1000K = 2'b11
    } ccr_fsw_e;

    // ==========================================
    // Host access carrier
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] cmd;
        logic [7:0] data;
    } ccr_req_s;

    // ==========================================
    // Decoded controls
    typedef struct packed {
        logic       cff_50pf;
        logic [9:0] ramp_uv10;
        logic       slave_fault_en;
        logic       output_discharge_en;
        logic [3:0] power_good_delay;
        logic [1:0] divider_range_sel;
        logic [2:0] divider_shift;
        ccr_fsw_e   fsw;
        logic       light_load_mode_sel;
    } ccr_ctrl_s;

endpackage

// ### core/ccr_power_good_delay.sv
`timescale 1ns/10ps
module ccr_power_good_delay
    import ccr_pkg::*;
#(
    parameter int MS_CYCLES = CCR_MS_CYCLES
) (
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       pg_raw,
    input  wire logic [3:0] delay_code,
    output logic            pg_out
);
    logic [3:0]  ms_reg;
    logic [31:0] cyc_reg;
    logic        pg_reg;
    wire         zero_delay = (delay_code == CCR_PGD_ZERO);
    wire         ms_tick    = (cyc_reg == 32'(MS_CYCLES - 1));
    wire         ms_done    = ms_tick && (ms_reg == delay_code);

    // ==========================================
    // Delay counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ms_reg  <= 4'h0;
            cyc_reg <= 32'h0;
            pg_reg  <= 1'b0;
        end else if (!pg_raw) begin
            ms_reg  <= 4'h0;
            cyc_reg <= 32'h0;
            pg_reg  <= 1'b0;
        end else if (!pg_reg) begin
            cyc_reg <= ms_tick ? 32'h0 : cyc_reg + 32'h1;
            ms_reg  <= ms_tick ? ms_reg + 4'h1 : ms_reg;
            pg_reg  <= ms_done;
        end
    end

    assign pg_out = pg_raw && (pg_reg || zero_delay);

    a_pg_zero_now : assert property (@(posedge clk) disable iff (!rstn)
        (pg_raw && zero_delay) |-> pg_out) else $error("zero delay not immediate");
endmodule

// ### core/ccr_config_regs.sv
// Behaviour
// - Compensation bit 4 picks feed-forward capacitor: 0 is 20pF, 1 is 50pF.
// - Ramp field bits 3:1 decoded through single- or multi-phase table.
// - Compensation bit 0, default 1, enables slave fault reporting on power-good.
// - Output-control bit 6 set: discharge output when control input falls low.
// - Bits 5:2 set power-good delay 1..15ms; code 1111 means none.
// - Bits 1:0 choose divider ratio 1, 0.5, 0.25, 0.125.
// - Operations bits 2:1 select 400, 600, 800 or 1000kHz switching.
// - Operations bit 0 zero gives pulse-skip, one gives forced continuous conduction.
// - Reset values: output-control 0x40, operations 0x05.
`timescale 1ns/10ps
module ccr_config_regs
    import ccr_pkg::*;
#(
    parameter int MS_CYCLES = CCR_MS_CYCLES
) (
    input  wire logic              clk,
    input  wire logic              rstn,
    input  wire ccr_pkg::ccr_req_s req,
    output logic [7:0]             rd_data,
    output logic                   rd_valid,
    output logic                   cmd_hit,
    input  wire logic              multiphase_select_bit,
    input  wire logic              ctrl_in,
    input  wire logic              pg_raw,
    input  wire logic              slave_fault,
    output ccr_pkg::ccr_ctrl_s     ctrl,
    output logic                   discharge_on,
    output logic                   power_good_pin
);
    import ccr_pkg::*;

    // ==========================================
    // Input synchronisers
    logic [1:0] ctrl_sync_reg;
    logic [1:0] mp_sync_reg;
    logic [1:0] pg_sync_reg;
    logic [1:0] sf_sync_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_sync_reg <= 2'b00;
            mp_sync_reg   <= 2'b00;
            pg_sync_reg   <= 2'b00;
            sf_sync_reg   <= 2'b00;
        end else begin
            ctrl_sync_reg <= {ctrl_sync_reg[0], ctrl_in};
            mp_sync_reg   <= {mp_sync_reg[0], multiphase_select_bit};
            pg_sync_reg   <= {pg_sync_reg[0], pg_raw};
            sf_sync_reg   <= {sf_sync_reg[0], slave_fault};
        end
    end

    wire ctrl_s = ctrl_sync_reg[1];
    wire mp_s   = mp_sync_reg[1];
    wire pg_s   = pg_sync_reg[1];
    wire sf_s   = sf_sync_reg[1];

    // ==========================================
    // Register file
    logic [7:0] comp_reg;
    logic [7:0] vout_reg;
    logic [7:0] ops_reg;
    logic [7:0] rd_data_reg;
    logic       rd_valid_reg;

    wire hit_comp = (req.cmd == CCR_CMD_COMP);
    wire hit_vout = (req.cmd == CCR_CMD_VOUT);
    wire hit_ops  = (req.cmd == CCR_CMD_OPS);
    wire [7:0] rd_mux = hit_comp ? comp_reg :
                        hit_vout ? vout_reg :
                        hit_ops  ? ops_reg  : 8'h00;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            comp_reg <= CCR_COMP_RST;
            vout_reg <= CCR_VOUT_RST;
            ops_reg  <= CCR_OPS_RST;
        end else if (req.wr) begin
            if (hit_comp) comp_reg <= req.data & CCR_COMP_MASK;
            if (hit_vout) vout_reg <= req.data & CCR_VOUT_MASK;
            if (hit_ops)  ops_reg  <= req.data & CCR_OPS_MASK;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_data_reg  <= 8'h00;
            rd_valid_reg <= 1'b0;
        end else begin
            rd_data_reg  <= req.rd ? rd_mux : rd_data_reg;
            rd_valid_reg <= req.rd;
        end
    end

    assign rd_data  = rd_data_reg;
    assign rd_valid = rd_valid_reg;
    assign cmd_hit  = hit_comp || hit_vout || hit_ops;

    // ==========================================
    // Ramp tables in units of 0.1mV
    wire [2:0] ramp_code = comp_reg[CCR_RAMP_LSB +: 3];
    logic [9:0] ramp_sp;
    logic [9:0] ramp_mp;

    always_comb begin
        unique case (ramp_code)
            3'h0: ramp_sp = 10'h038;
            3'h1: ramp_sp = 10'h062;
            3'h2: ramp_sp = 10'h0b4;
            3'h3: ramp_sp = 10'h12c;
            3'h4: ramp_sp = 10'h055;
            3'h5: ramp_sp = 10'h097;
            3'h6: ramp_sp = 10'h10e;
            3'h7: ramp_sp = 10'h1b8;
        endcase
    end

    always_comb begin
        unique case (ramp_code)
            3'h0: ramp_mp = 10'h056;
            3'h1: ramp_mp = 10'h096;
            3'h2: ramp_mp = 10'h10e;
            3'h3: ramp_mp = 10'h1c2;
            3'h4: ramp_mp = 10'h082;
            3'h5: ramp_mp = 10'h0e6;
            3'h6: ramp_mp = 10'h19a;
            3'h7: ramp_mp = 10'h2a8;
        endcase
    end

    // ==========================================
    // Decoded controls
    assign ctrl.cff_50pf            = comp_reg[CCR_CFF_BIT];
    assign ctrl.ramp_uv10           = mp_s ? ramp_mp : ramp_sp;
    assign ctrl.slave_fault_en      = comp_reg[CCR_SLAVE_BIT];
    assign ctrl.output_discharge_en = vout_reg[CCR_DISCH_BIT];
    assign ctrl.power_good_delay    = vout_reg[CCR_PGD_LSB +: 4];
    assign ctrl.divider_range_sel   = vout_reg[CCR_RANGE_LSB +: 2];
    assign ctrl.divider_shift       = {1'b0, vout_reg[CCR_RANGE_LSB +: 2]};
    assign ctrl.fsw                 = ccr_fsw_e'(ops_reg[CCR_FSW_LSB +: 2]);
    assign ctrl.light_load_mode_sel = ops_reg[CCR_LLM_BIT];

    assign discharge_on = ctrl.output_discharge_en && !ctrl_s;

    // ==========================================
    // Power-good generation
    logic pg_delayed;
    wire  pg_qual = pg_s && ctrl_s && !(ctrl.slave_fault_en && sf_s);

    ccr_power_good_delay #(
        .MS_CYCLES (MS_CYCLES)
    ) u_power_good_delay (
        .clk        (clk),
        .rstn       (rstn),
        .pg_raw     (pg_qual),
        .delay_code (ctrl.power_good_delay),
        .pg_out     (pg_delayed)
    );

    assign power_good_pin = pg_delayed;

    // ==========================================
    // Checks
    a_vout_rst_val : assert property (@(posedge clk)
        $rose(rstn) |-> (vout_reg == 8'h40 && ops_reg == 8'h05)) else $error("bad reset values");
    a_wr_applies : assert property (@(posedge clk) disable iff (!rstn)
        (req.wr && hit_ops) |=> (ops_reg == ($past(req.data) & 8'h07))) else $error("ops write lost");
    a_resv_zero : assert property (@(posedge clk) disable iff (!rstn)
        (comp_reg[7:5] == 3'h0 && vout_reg[7] == 1'b0 && ops_reg[7:3] == 5'h00)) else $error("reserved set");
    a_cff_track : assert property (@(posedge clk) disable iff (!rstn)
        (req.wr && hit_comp) |=> (ctrl.cff_50pf == $past(req.data[4]))) else $error("cff not applied");
    a_ramp_mp_big : assert property (@(posedge clk) disable iff (!rstn)
        mp_s |-> (ctrl.ramp_uv10 > ramp_sp)) else $error("ramp table wrong");
    a_slave_block : assert property (@(posedge clk) disable iff (!rstn)
        (ctrl.slave_fault_en && sf_s) |-> !power_good_pin) else $error("slave fault ignored");
    a_discharge : assert property (@(posedge clk) disable iff (!rstn)
        $fell(ctrl_s) |-> (discharge_on == vout_reg[6])) else $error("discharge wrong");
    a_fsw_map : assert property (@(posedge clk) disable iff (!rstn)
        (req.wr && hit_ops) |=> (ctrl.fsw == ccr_fsw_e'($past(req.data[2:1])))) else $error("fsw wrong");
    a_llm_map : assert property (@(posedge clk) disable iff (!rstn)
        (req.wr && hit_ops) |=> (ctrl.light_load_mode_sel == $past(req.data[0]))) else $error("llm wrong");
    a_range_map : assert property (@(posedge clk) disable iff (!rstn)
        ctrl.divider_shift[1:0] == vout_reg[1:0]) else $error("range wrong");
endmodule

// ### dv/ccr_host_model.sv
`timescale 1ns/10ps
module ccr_host_model
    import ccr_pkg::*;
(
    input  wire logic         clk,
    input  wire logic [7:0]   rd_data,
    input  wire logic         rd_valid,
    output ccr_pkg::ccr_req_s req
);
    // ==========================================
    // Host byte accesses, one taken edge each
    initial req = '0;

    task automatic write_byte(input logic [7:0] cmd, input logic [7:0] data);
        @(posedge clk);
        req <= {1'b1, 1'b0, cmd, data};
        @(posedge clk);
        req <= {1'b0, 1'b0, ~cmd, ~data};
        #1;
    endtask

    task automatic read_byte(input logic [7:0] cmd, output logic [7:0] data, output logic valid);
        @(posedge clk);
        req <= {1'b0, 1'b1, cmd, 8'h5a};
        @(posedge clk);
        req <= {1'b0, 1'b0, ~cmd, 8'ha5};
        #1;
        data = rd_data;
        valid = rd_valid;
    endtask
endmodule

// ### dv/ccr_config_regs_tb.sv
`timescale 1ns/10ps
module ccr_config_regs_tb;
    import ccr_pkg::*;
    localparam int MS = 10;
    // Ramp amplitudes in 0.1mV, single-phase then multi-phase
    function automatic logic [9:0] ramp_ref(input int idx);
        case (idx)
            0: ramp_ref = 10'h038;
            1: ramp_ref = 10'h062;
            2: ramp_ref = 10'h0b4;
            3: ramp_ref = 10'h12c;
            4: ramp_ref = 10'h055;
            5: ramp_ref = 10'h097;
            6: ramp_ref = 10'h10e;
            7: ramp_ref = 10'h1b8;
            8: ramp_ref = 10'h056;
            9: ramp_ref = 10'h096;
            10: ramp_ref = 10'h10e;
            11: ramp_ref = 10'h1c2;
            12: ramp_ref = 10'h082;
            13: ramp_ref = 10'h0e6;
            14: ramp_ref = 10'h19a;
            15: ramp_ref = 10'h2a8;
            default: ramp_ref = 10'h000;
        endcase
    endfunction
    logic       clk = 1'b0;
    logic       rstn = 1'b0;
    logic       multiphase_select_bit = 1'b0;
    logic       ctrl_in = 1'b0;
    logic       pg_raw = 1'b0;
    logic       slave_fault = 1'b0;
    ccr_req_s   req;
    ccr_ctrl_s  ctrl;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       discharge_on;
    logic       power_good_pin;
    logic       cmd_hit;
    wire        exp_hit = (req.cmd == CCR_CMD_COMP) || (req.cmd == CCR_CMD_VOUT) || (req.cmd == CCR_CMD_OPS);
    logic [7:0] rv;
    logic       vv;
    int         err_total = 0;
    int         comparisons = 0;
    int         cycles = 0;

    always #4 clk = ~clk;

    ccr_host_model host_u (.clk(clk), .rd_data(rd_data), .rd_valid(rd_valid), .req(req));

    ccr_config_regs #(.MS_CYCLES(MS)) dut_u (
        .clk(clk), .rstn(rstn), .req(req), .rd_data(rd_data), .rd_valid(rd_valid), .cmd_hit(cmd_hit),
        .multiphase_select_bit(multiphase_select_bit), .ctrl_in(ctrl_in), .pg_raw(pg_raw),
        .slave_fault(slave_fault), .ctrl(ctrl), .discharge_on(discharge_on), .power_good_pin(power_good_pin));

    // ==========================================
    // Shared checks
    task automatic print_verdict();
        if (err_total == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_total++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] cmd, input logic [7:0] exp);
        host_u.read_byte(cmd, rv, vv);
        check({7'h00, vv, rv}, {8'h01, exp});
    endtask

    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask

    task automatic pg_meas(input logic [3:0] code, input int lo, input int hi);
        int n;
        n = 0;
        host_u.write_byte(CCR_CMD_VOUT, {2'b00, code, 2'b00});
        @(posedge clk);
        pg_raw <= 1'b0;
        settle();
        check(16'(power_good_pin), 16'h0000);
        @(posedge clk);
        pg_raw <= 1'b1;
        while (power_good_pin !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(16'(n >= lo && n <= hi), 16'h0001);
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    // ==========================================
    // Command decode at each taken read
    always @(posedge clk) begin
        if (rstn && req.rd) begin
            comparisons++;
            if (cmd_hit !== exp_hit) begin
                err_total++;
                $display("Error %0t: command decode wrong", $time);
            end
        end
    end

    // ==========================================
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd_chk(CCR_CMD_COMP, 8'h09);
        rd_chk(CCR_CMD_VOUT, 8'h40);
        rd_chk(CCR_CMD_OPS, 8'h05);
        check(16'({ctrl.output_discharge_en, ctrl.fsw, ctrl.light_load_mode_sel}), 16'h000d);
        host_u.write_byte(CCR_CMD_COMP, 8'hff);
        host_u.write_byte(CCR_CMD_VOUT, 8'hff);
        host_u.write_byte(CCR_CMD_OPS, 8'hff);
        host_u.write_byte(8'he0, 8'h00);
        rd_chk(CCR_CMD_COMP, 8'h1f);
        rd_chk(CCR_CMD_VOUT, 8'h7f);
        rd_chk(CCR_CMD_OPS, 8'h07);
        rd_chk(8'he0, 8'h00);
        for (int i = 0; i < 8; i++) begin
            host_u.write_byte(CCR_CMD_OPS, 8'(i));
            check(16'({ctrl.fsw, ctrl.light_load_mode_sel}), 16'(i));
        end
        for (int i = 0; i < 4; i++) begin
            host_u.write_byte(CCR_CMD_VOUT, 8'(i));
            check(16'({ctrl.divider_range_sel, ctrl.divider_shift}), 16'(i * 9));
        end
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            multiphase_select_bit <= p[0];
            settle();
            for (int r = 0; r < 8; r++) begin
                host_u.write_byte(CCR_CMD_COMP, {3'h0, r[0], r[2:0], ~r[0]});
                check(16'({ctrl.cff_50pf, ctrl.ramp_uv10, ctrl.slave_fault_en}),
                      16'({r[0], ramp_ref(p * 8 + r), ~r[0]}));
            end
        end
        // ==========================================
        // Discharge on control input low
        host_u.write_byte(CCR_CMD_VOUT, 8'h40);
        settle();
        check(16'(discharge_on), 16'h0001);
        @(posedge clk);
        ctrl_in <= 1'b1;
        settle();
        check(16'(discharge_on), 16'h0000);
        host_u.write_byte(CCR_CMD_VOUT, 8'h00);
        @(posedge clk);
        ctrl_in <= 1'b0;
        settle();
        check(16'(discharge_on), 16'h0000);
        @(posedge clk);
        ctrl_in <= 1'b1;
        // ==========================================
        // Power-good delay and slave fault gating
        host_u.write_byte(CCR_CMD_COMP, 8'h01);
        pg_meas(4'h0, MS, MS + 4);
        pg_meas(4'h2, 3 * MS, 3 * MS + 4);
        pg_meas(4'hf, 1, 4);
        @(posedge clk);
        slave_fault <= 1'b1;
        settle();
        check(16'(power_good_pin), 16'h0000);
        host_u.write_byte(CCR_CMD_COMP, 8'h00);
        settle();
        check(16'(power_good_pin), 16'h0001);
        print_verdict();
    end
endmodule
